// *** design/uoec_device.sv ***
// OUT endpoint end: packet FIFO, handshakes and the firmware register set over AHB-Lite.
// Assumes one AHB-Lite master, the host end on the same hclk, and firmware that reacts to irq.
`include "uoec_params.svh"
module uoec_device
  import uoec_pkg::*;
#(
  parameter int SLOT_BYTES = 64
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  uoec_link_if.dev link
);
  localparam int AW = $clog2(SLOT_BYTES);

  // ********************************
  // Register and FIFO state
  // ********************************
  logic [7:0] mem [2*SLOT_BYTES];
  logic [9:0] cnt_reg [2];
  logic [1:0] err_reg;
  logic [1:0] pkts_reg;
  logic wr_slot_reg, rd_slot_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [9:0] rx_cnt_reg;
  logic opr_reg, ovr_reg, flush_reg, sstl_reg, stsent_reg, toggle_reg;
  logic dbl_reg, iso_reg;
  uoec_dev_state_e state_reg;
  uoec_hs_e drop_code_reg;
  logic [7:0] addr_reg;
  logic wr_pend_reg, rd_pend_reg;

  // ********************************
  // Bus decode
  // ********************************
  wire addr_ph = hsel && htrans[1] && hready;
  wire wr_low = wr_pend_reg && (addr_reg == `UOEC_IDX_CTRL_LOW);
  wire wr_high = wr_pend_reg && (addr_reg == `UOEC_IDX_CTRL_HIGH);
  wire rd_fifo = rd_pend_reg && (addr_reg == `UOEC_IDX_FIFO_DATA) && opr_reg;
  wire [7:0] wlo = hwdata[7:0];

  // ********************************
  // Packet accounting
  // ********************************
  wire full = (pkts_reg == (dbl_reg ? 2'd2 : 2'd1));
  wire clr_opr = wr_low && !wlo[`UOEC_B_PKT_READY] && opr_reg;
  wire flush_go = flush_reg && (pkts_reg != 2'd0);
  wire release_pkt = clr_opr || flush_go;
  wire end_rx = (state_reg == UOEC_D_RECV) && link.dat_valid && link.dat_last;
  wire bulk_bad_crc = !iso_reg && link.dat_crc_err;
  wire bulk_dup = !iso_reg && (link.dat_pid != toggle_reg);
  wire commit = end_rx && !bulk_bad_crc && !bulk_dup;
  wire [1:0] pkts_next = pkts_reg + {1'b0, commit} - {1'b0, release_pkt};
  wire set_opr = (!opr_reg || release_pkt) && (pkts_next != 2'd0);
  wire tok_take = (state_reg == UOEC_D_IDLE) && link.tok_valid;
  wire ovr_set = tok_take && !sstl_reg && iso_reg && full;
  wire stall_tx = (state_reg == UOEC_D_DROP) && link.dat_valid && link.dat_last
    && (drop_code_reg == UOEC_HS_STALL);
  wire [9:0] head_cnt = opr_reg ? cnt_reg[rd_slot_reg] : 10'h000;
  wire head_err = opr_reg && iso_reg && err_reg[rd_slot_reg];
  wire [AW:0] wr_idx = {wr_slot_reg, rx_cnt_reg[AW-1:0]};
  wire [AW:0] rd_idx = {rd_slot_reg, rd_ptr_reg};
  wire mem_we = (state_reg == UOEC_D_RECV) && link.dat_valid && (rx_cnt_reg < 10'(SLOT_BYTES));
  wire [7:0] ctrl_low_rd = {1'b0, stsent_reg, sstl_reg, flush_reg, head_err, ovr_reg,
    full, opr_reg};
  wire [7:0] ctrl_high_rd = {dbl_reg, iso_reg, 6'h00};
  wire [7:0] rd_byte =
    (addr_reg == `UOEC_IDX_CTRL_LOW) ? ctrl_low_rd :
    (addr_reg == `UOEC_IDX_CTRL_HIGH) ? ctrl_high_rd :
    (addr_reg == `UOEC_IDX_COUNT_LOW) ? head_cnt[7:0] :
    (addr_reg == `UOEC_IDX_COUNT_HIGH) ? {6'h00, head_cnt[9:8]} :
    (addr_reg == `UOEC_IDX_FIFO_DATA && opr_reg) ? mem[rd_idx] : 8'h00;

  // ********************************
  // AHB-Lite slave
  // ********************************
  // Reads take one wait state so that a write just ahead is already visible.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 8'h00;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end else begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      if (addr_ph) begin
        addr_reg <= haddr[9:2];
        wr_pend_reg <= hwrite;
        rd_pend_reg <= !hwrite;
        hreadyout <= hwrite;
      end else if (rd_pend_reg) begin
        hrdata <= {24'h000000, rd_byte};
        hreadyout <= 1'b1;
      end
    end
  end

  // ********************************
  // Firmware controls and flags
  // ********************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {stsent_reg, sstl_reg, flush_reg, ovr_reg} <= 4'h0;
      opr_reg <= 1'b0;
      dbl_reg <= 1'b0;
      iso_reg <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (wr_high) begin
        dbl_reg <= wlo[`UOEC_B_DBL_BUF];
        iso_reg <= wlo[`UOEC_B_ISO];
      end
      if (wr_low) sstl_reg <= wlo[`UOEC_B_SEND_STALL];
      flush_reg <= wr_low && wlo[`UOEC_B_FLUSH];
      // Hardware set wins over a firmware clear in the same cycle.
      ovr_reg <= ovr_set || (ovr_reg && !(wr_low && !wlo[`UOEC_B_OVERRUN]));
      stsent_reg <= stall_tx
        || (stsent_reg && !(wr_low && !wlo[`UOEC_B_STALL_SENT]));
      opr_reg <= set_opr || (opr_reg && !release_pkt);
      irq <= set_opr || stall_tx || ovr_set;
    end
  end

  // ********************************
  // Link receive and handshakes
  // ********************************
  // The packet store has no reset; a byte is only read while its packet stands.
  always_ff @(posedge hclk) begin
    if (mem_we) mem[wr_idx] <= link.dat_byte;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= UOEC_D_IDLE;
      drop_code_reg <= UOEC_HS_NONE;
      rx_cnt_reg <= 10'h000;
      toggle_reg <= 1'b0;
      pkts_reg <= 2'd0;
      wr_slot_reg <= 1'b0;
      rd_slot_reg <= 1'b0;
      rd_ptr_reg <= '0;
      err_reg <= 2'b00;
      cnt_reg[0] <= 10'h000;
      cnt_reg[1] <= 10'h000;
      link.hs_valid <= 1'b0;
      link.hs_code <= UOEC_HS_NONE;
    end else begin
      link.hs_valid <= 1'b0;
      pkts_reg <= pkts_next;
      if (release_pkt) begin
        rd_slot_reg <= !rd_slot_reg;
        rd_ptr_reg <= '0;
      end else if (rd_fifo) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (wr_low && wlo[`UOEC_B_CLR_TOGGLE]) toggle_reg <= 1'b0;
      case (state_reg)
        UOEC_D_IDLE: begin
          rx_cnt_reg <= 10'h000;
          if (link.tok_valid) begin
            if (sstl_reg) begin
              drop_code_reg <= UOEC_HS_STALL;
              state_reg <= UOEC_D_DROP;
            end else if (full) begin
              drop_code_reg <= iso_reg ? UOEC_HS_NONE : UOEC_HS_NAK;
              state_reg <= UOEC_D_DROP;
            end else begin
              state_reg <= UOEC_D_RECV;
            end
          end
        end
        UOEC_D_RECV: begin
          if (link.dat_valid) begin
            if (rx_cnt_reg != 10'h3FF) rx_cnt_reg <= rx_cnt_reg + 10'h001;
            if (link.dat_last) begin
              state_reg <= UOEC_D_IDLE;
              // A bulk packet with bad CRC gets no answer; a repeated one is acked, dropped.
              link.hs_valid <= !iso_reg && !bulk_bad_crc;
              link.hs_code <= UOEC_HS_ACK;
              if (commit) begin
                cnt_reg[wr_slot_reg] <= (rx_cnt_reg == 10'h3FF) ? rx_cnt_reg
                                                                 : rx_cnt_reg + 10'h001;
                err_reg[wr_slot_reg] <= iso_reg && link.dat_crc_err;
                wr_slot_reg <= !wr_slot_reg;
                if (!iso_reg) toggle_reg <= !toggle_reg;
              end
            end
          end
        end
        UOEC_D_DROP: begin
          if (link.dat_valid && link.dat_last) begin
            state_reg <= UOEC_D_IDLE;
            link.hs_valid <= (drop_code_reg != UOEC_HS_NONE);
            link.hs_code <= drop_code_reg;
          end
        end
        default: state_reg <= UOEC_D_IDLE;
      endcase
    end
  end
endmodule

// *** design/uoec_host.sv ***
// Host end: sends one OUT token and data packet per command, reports the handshake.
// Assumes the device end shares hclk; link inputs need no synchroniser.
`include "uoec_params.svh"
module uoec_host
  import uoec_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [9:0] cmd_len,
  input wire logic [7:0] cmd_seed,
  input wire logic cmd_crc_err,
  input wire logic cmd_pid,
  output logic res_valid,
  output uoec_hs_e res_code,
  uoec_link_if.host link
);
  uoec_host_state_e state_reg, state_next;
  logic [9:0] len_reg;
  logic [9:0] idx_reg;
  logic [7:0] seed_reg;
  logic crc_reg;
  logic [15:0] wait_reg;

  wire take_cmd = (state_reg == UOEC_H_IDLE) && cmd_valid;
  wire last_byte = (idx_reg + 10'h001) >= len_reg;
  wire timed_out = wait_reg >= `UOEC_HS_TIMEOUT;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      UOEC_H_IDLE: if (cmd_valid) state_next = UOEC_H_TOKEN;
      UOEC_H_TOKEN: state_next = last_byte ? UOEC_H_WAIT : UOEC_H_DATA;
      UOEC_H_DATA: if (last_byte) state_next = UOEC_H_WAIT;
      UOEC_H_WAIT: if (link.hs_valid || timed_out) state_next = UOEC_H_IDLE;
      default: state_next = UOEC_H_IDLE;
    endcase
  end

  // ********************************
  // Sequencing and link drive
  // ********************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= UOEC_H_IDLE;
      len_reg <= 10'h000;
      idx_reg <= 10'h000;
      seed_reg <= 8'h00;
      crc_reg <= 1'b0;
      wait_reg <= 16'h0000;
      cmd_ready <= 1'b0;
      res_valid <= 1'b0;
      res_code <= UOEC_HS_NONE;
      link.tok_valid <= 1'b0;
      link.dat_valid <= 1'b0;
      link.dat_byte <= 8'h00;
      link.dat_last <= 1'b0;
      link.dat_crc_err <= 1'b0;
      link.dat_pid <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmd_ready <= (state_next == UOEC_H_IDLE);
      res_valid <= 1'b0;
      link.tok_valid <= 1'b0;
      link.dat_valid <= 1'b0;
      link.dat_last <= 1'b0;
      link.dat_crc_err <= 1'b0;
      if (take_cmd) begin
        len_reg <= (cmd_len == 10'h000) ? 10'h001 : cmd_len;
        seed_reg <= cmd_seed;
        crc_reg <= cmd_crc_err;
        link.dat_pid <= cmd_pid;
        idx_reg <= 10'h000;
        link.tok_valid <= 1'b1;
      end
      // Byte zero goes out in the token state, so the index must advance there too.
      if (state_reg == UOEC_H_TOKEN || state_reg == UOEC_H_DATA) begin
        link.dat_valid <= 1'b1;
        link.dat_byte <= seed_reg + idx_reg[7:0];
        link.dat_last <= last_byte;
        link.dat_crc_err <= crc_reg;
        idx_reg <= idx_reg + 10'h001;
      end
      if (state_reg == UOEC_H_WAIT) begin
        wait_reg <= wait_reg + 16'h0001;
        if (link.hs_valid || timed_out) begin
          res_valid <= 1'b1;
          res_code <= link.hs_valid ? link.hs_code : UOEC_HS_NONE;
          wait_reg <= 16'h0000;
        end
      end
    end
  end
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench: host end and endpoint end joined by the link interface.
// Assumes the package, the interface and both design ends are compiled first.
module tb_top
  import uoec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************
  // Signals and instances
  // ********************************
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic cmd_valid = 1'h0;
  logic [9:0] cmd_len = 10'h0;
  logic [7:0] cmd_seed = 8'h0;
  logic cmd_crc_err = 1'h0;
  logic cmd_pid = 1'h0;
  logic cmd_ready;
  logic res_valid;
  uoec_hs_e res_code;
  logic [31:0] rv;
  int failures = 0;
  int checks_done = 0;
  int irq_cnt = 0;
  int base;

  always #2.5 hclk = ~hclk;
  always @(posedge hclk) if (irq === 1'h1) irq_cnt++;

  uoec_link_if link ();
  uoec_host u_uoec_host (.hclk(hclk), .hresetn(hresetn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_len(cmd_len), .cmd_seed(cmd_seed), .cmd_crc_err(cmd_crc_err),
    .cmd_pid(cmd_pid), .res_valid(res_valid), .res_code(res_code), .link(link));
  uoec_device #(.SLOT_BYTES(64)) u_uoec_device (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .link(link));
  uoec_link_properties u_uoec_link_properties (.hclk(hclk), .hresetn(hresetn),
    .tok_valid(link.tok_valid), .dat_valid(link.dat_valid), .dat_byte(link.dat_byte),
    .dat_last(link.dat_last), .dat_pid(link.dat_pid), .hs_valid(link.hs_valid),
    .hs_code(link.hs_code));

  // ********************************
  // Tasks
  // ********************************
  task automatic close_out();
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_hs(input string nm, input uoec_hs_e exp, input uoec_hs_e got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic sig(input int w);
    return (w == 0) ? hreadyout : ((w == 1) ? cmd_ready : res_valid);
  endfunction
  // Waits for a rising edge that samples the chosen signal high, within a bound.
  task automatic wait_hi(input int w);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (sig(w) !== 1'h1 && n < 64);
    if (sig(w) !== 1'h1) begin
      failures++;
      close_out();
    end
  endtask
  task automatic ahb(input logic [7:0] idx, input logic w, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    wait_hi(0);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_hi(0);
    rv = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    ahb(idx, 1'h1, {24'h0, d});
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    ahb(idx, 1'h0, 32'h0);
    chk(nm, {24'h0, exp}, rv);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic send(input logic [9:0] len, input logic [7:0] seed, input logic crc,
    input logic pid, input uoec_hs_e exp);
    cmd_valid <= 1'h1;
    cmd_len <= len;
    cmd_seed <= seed;
    cmd_crc_err <= crc;
    cmd_pid <= pid;
    wait_hi(1);
    cmd_valid <= 1'h0;
    wait_hi(2);
    chk_hs("res_code", exp, res_code);
  endtask

  // ********************************
  // Sequence
  // ********************************
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd_chk("ctrl_low", 8'h14, 8'h00);
    rd_chk("ctrl_high", 8'h15, 8'h00);
    rd_chk("unmapped", 8'h30, 8'h00);
    base = irq_cnt;
    send(10'h3, 8'hA0, 1'h0, 1'h0, UOEC_HS_ACK);
    rd_chk("ctrl_low", 8'h14, 8'h03);
    chk("irq", 32'(base + 1), 32'(irq_cnt));
    rd_chk("count_low", 8'h16, 8'h03);
    rd_chk("count_high", 8'h17, 8'h00);
    for (int i = 0; i < 3; i++) rd_chk("fifo", 8'h18, 8'(8'hA0 + i));
    wr(8'h14, 8'h00);
    rd_chk("count_low", 8'h16, 8'h00);
    // A repeated toggle is acknowledged but must not be stored.
    send(10'h1, 8'h11, 1'h0, 1'h0, UOEC_HS_ACK);
    rd_chk("ctrl_low", 8'h14, 8'h00);
    wr(8'h14, 8'h80);
    rd_chk("ctrl_low", 8'h14, 8'h00);
    send(10'h1, 8'h22, 1'h0, 1'h0, UOEC_HS_ACK);
    rd_chk("ctrl_low", 8'h14, 8'h03);
    send(10'h1, 8'h33, 1'h0, 1'h1, UOEC_HS_NAK);
    wr(8'h14, 8'h11);
    repeat (3) @(posedge hclk);
    rd_chk("ctrl_low", 8'h14, 8'h00);
    wr(8'h15, 8'h80);
    send(10'h1, 8'h10, 1'h0, 1'h1, UOEC_HS_ACK);
    send(10'h2, 8'h20, 1'h0, 1'h0, UOEC_HS_ACK);
    rd_chk("ctrl_low", 8'h14, 8'h03);
    rd_chk("count_low", 8'h16, 8'h01);
    base = irq_cnt;
    wr(8'h14, 8'h00);
    rd_chk("ctrl_low", 8'h14, 8'h01);
    rd_chk("count_low", 8'h16, 8'h02);
    chk("irq", 32'(base + 1), 32'(irq_cnt));
    rd_chk("fifo", 8'h18, 8'h20);
    wr(8'h14, 8'h00);
    wr(8'h14, 8'h20);
    base = irq_cnt;
    send(10'h1, 8'h44, 1'h0, 1'h1, UOEC_HS_STALL);
    send(10'h1, 8'h45, 1'h0, 1'h0, UOEC_HS_STALL);
    rd_chk("ctrl_low", 8'h14, 8'h60);
    chk("irq", 32'(base + 2), 32'(irq_cnt));
    wr(8'h14, 8'h00);
    rd_chk("ctrl_low", 8'h14, 8'h00);
    wr(8'h15, 8'hC0);
    send(10'h4, 8'h50, 1'h1, 1'h0, UOEC_HS_NONE);
    rd_chk("ctrl_low", 8'h14, 8'h09);
    rd_chk("fifo", 8'h18, 8'h50);
    send(10'h2, 8'h60, 1'h0, 1'h1, UOEC_HS_NONE);
    rd_chk("ctrl_low", 8'h14, 8'h0B);
    base = irq_cnt;
    send(10'h2, 8'h70, 1'h0, 1'h0, UOEC_HS_NONE);
    rd_chk("ctrl_low", 8'h14, 8'h0F);
    chk("irq", 32'(base + 1), 32'(irq_cnt));
    // Clear packet-ready but keep the overrun flag; the errored head packet goes away.
    wr(8'h14, 8'h04);
    rd_chk("ctrl_low", 8'h14, 8'h05);
    rd_chk("count_low", 8'h16, 8'h02);
    wr(8'h14, 8'h00);
    rd_chk("ctrl_low", 8'h14, 8'h00);
    close_out();
  end
endmodule

// *** dv/uoec_link_properties.sv ***
// Checker of the packet link between the host end and the endpoint end.
// Assumes it is instantiated beside the link interface, on the shared hclk.
module uoec_link_properties
  import uoec_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tok_valid,
  input wire logic dat_valid,
  input wire logic [7:0] dat_byte,
  input wire logic dat_last,
  input wire logic dat_pid,
  input wire logic hs_valid,
  input uoec_hs_e hs_code
);
  // ********************************
  // Link properties
  // ********************************
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_mid;
    dat_valid && !dat_last;
  endsequence
  sequence s_last;
    dat_valid && dat_last;
  endsequence

  property p_hs_after_last;
    hs_valid |-> $past(dat_valid && dat_last);
  endproperty
  property p_hs_pulse;
    hs_valid |=> !hs_valid;
  endproperty
  property p_hs_code;
    hs_valid |-> hs_code != UOEC_HS_NONE;
  endproperty
  property p_tok_then_data;
    tok_valid |=> dat_valid;
  endproperty
  property p_bytes_run;
    s_mid |=> dat_valid && !tok_valid;
  endproperty
  property p_pid_stable;
    s_mid |=> $stable(dat_pid);
  endproperty
  property p_byte_step;
    s_mid |=> dat_byte == 8'($past(dat_byte) + 8'h01);
  endproperty
  // The host must leave room for the handshake before a new packet.
  property p_quiet_after_last;
    s_last |=> !dat_valid [*2];
  endproperty

  a_hs_after_last: assert property (p_hs_after_last) else $error("handshake without last byte");
  a_hs_pulse: assert property (p_hs_pulse) else $error("handshake longer than one cycle");
  a_hs_code: assert property (p_hs_code) else $error("handshake with no code");
  a_tok_then_data: assert property (p_tok_then_data) else $error("token not followed by data");
  a_bytes_run: assert property (p_bytes_run) else $error("packet bytes not contiguous");
  a_pid_stable: assert property (p_pid_stable) else $error("pid changed inside packet");
  a_byte_step: assert property (p_byte_step) else $error("packet byte out of order");
  a_quiet_after_last: assert property (p_quiet_after_last) else $error("data right after last");
endmodule

// *** pkg/uoec_link_if.sv ***
// Packet link between the host end and the OUT endpoint end.
// Assumes both ends run on the same hclk.
interface uoec_link_if;
  import uoec_pkg::*;
  logic tok_valid;
  logic dat_valid;
  logic [7:0] dat_byte;
  logic dat_last;
  logic dat_crc_err;
  logic dat_pid;
  logic hs_valid;
  uoec_hs_e hs_code;

  modport host (
    output tok_valid,
    output dat_valid,
    output dat_byte,
    output dat_last,
    output dat_crc_err,
    output dat_pid,
    input hs_valid,
    input hs_code
  );

  modport dev (
    input tok_valid,
    input dat_valid,
    input dat_byte,
    input dat_last,
    input dat_crc_err,
    input dat_pid,
    output hs_valid,
    output hs_code
  );
endinterface

// *** pkg/uoec_params.svh ***
// Register indices, field positions, reset values and timing counts of the OUT endpoint.
// Assumes it is included by bare name by the package and both ends.
`ifndef UOEC_PARAMS_SVH
`define UOEC_PARAMS_SVH

// ********************************
// Register indices, byte address is four times the index
// ********************************
`define UOEC_IDX_CTRL_LOW 8'h14
`define UOEC_IDX_CTRL_HIGH 8'h15
`define UOEC_IDX_COUNT_LOW 8'h16
`define UOEC_IDX_COUNT_HIGH 8'h17
`define UOEC_IDX_FIFO_DATA 8'h18

// ********************************
// Control low fields
// ********************************
`define UOEC_B_PKT_READY 0
`define UOEC_B_FIFO_FULL 1
`define UOEC_B_OVERRUN 2
`define UOEC_B_DATA_ERR 3
`define UOEC_B_FLUSH 4
`define UOEC_B_SEND_STALL 5
`define UOEC_B_STALL_SENT 6
`define UOEC_B_CLR_TOGGLE 7

// ********************************
// Control high fields
// ********************************
`define UOEC_B_DBL_BUF 7
`define UOEC_B_ISO 6

// ********************************
// Reset values and timing
// ********************************
`define UOEC_RST_CTRL_LOW 8'h00
`define UOEC_RST_CTRL_HIGH 8'h00
`define UOEC_HS_TIMEOUT 16'h0010

`endif

// *** pkg/uoec_pkg.sv ***
// Types shared by both ends of the OUT endpoint link.
// Assumes uoec_params.svh sits on the include path.
`include "uoec_params.svh"
package uoec_pkg;
  typedef enum logic [1:0] {
    UOEC_HS_NONE = 2'b00,
    UOEC_HS_ACK = 2'b01,
    UOEC_HS_NAK = 2'b10,
    UOEC_HS_STALL = 2'b11
  } uoec_hs_e;

  typedef enum logic [1:0] {
    UOEC_D_IDLE = 2'b00,
    UOEC_D_RECV = 2'b01,
    UOEC_D_DROP = 2'b10
  } uoec_dev_state_e;

  typedef enum logic [1:0] {
    UOEC_H_IDLE = 2'b00,
    UOEC_H_TOKEN = 2'b01,
    UOEC_H_DATA = 2'b10,
    UOEC_H_WAIT = 2'b11
  } uoec_host_state_e;
endpackage
